// file: dso_cfg.svh
`ifndef DSO_CFG_SVH
`define DSO_CFG_SVH

// object dictionary indexes
`define DSO_IDX_STATUS 16'h6041
`define DSO_IDX_QSTOP 16'h605a
`define DSO_IDX_SHUT 16'h605b
`define DSO_IDX_DISOP 16'h605c
`define DSO_IDX_FAULT 16'h605e

// option code reset values
`define DSO_RST_QSTOP 16'h0002
`define DSO_RST_SHUT 16'h0000
`define DSO_RST_DISOP 16'h0001
`define DSO_RST_FAULT 16'h0002

// accepted option values, bit n set means value n is legal
`define DSO_OK_QSTOP 16'h0067
`define DSO_OK_SHUT 16'h0003
`define DSO_OK_DISOP 16'h0003
`define DSO_OK_FAULT 16'h0007

// option code values
`define DSO_OPT_DISABLE 16'h0000
`define DSO_OPT_SLOW 16'h0001
`define DSO_OPT_QUICK 16'h0002
`define DSO_OPT_SLOW_STAY 16'h0005
`define DSO_OPT_QUICK_STAY 16'h0006

// status word bit positions
`define DSO_SW_RTSO 0
`define DSO_SW_SO 1
`define DSO_SW_OE 2
`define DSO_SW_FAULT 3
`define DSO_SW_VOLT 4
`define DSO_SW_QS 5
`define DSO_SW_SOD 6
`define DSO_SW_WARN 7
`define DSO_SW_REMOTE 9
`define DSO_SW_TR 10
`define DSO_SW_ILIM 11
`define DSO_SW_MS0 12
`define DSO_SW_MS1 13

// control word bit positions and reserved mask
`define DSO_CW_SO 0
`define DSO_CW_EV 1
`define DSO_CW_QS 2
`define DSO_CW_EO 3
`define DSO_CW_FR 7
`define DSO_CW_HALT 8
`define DSO_CW_RSV_MASK 16'h0600

// operation mode codes
`define DSO_MODE_PROF_POS 8'h01
`define DSO_MODE_PROF_VEL 8'h03
`define DSO_MODE_HOME_SEARCH 8'h06
`define DSO_MODE_INTERP_POS 8'h07

`endif

// file: dso_pkg.sv
package dso_pkg;

  // device control states
  typedef enum logic [2:0] {
    st_not_ready = 3'b000,
    st_sw_on_disabled = 3'b001,
    st_ready = 3'b010,
    st_switched_on = 3'b011,
    st_op_enabled = 3'b100,
    st_quick_stop = 3'b101,
    st_fault_react = 3'b110,
    st_fault = 3'b111
  } dso_state_t;

  // ramp applied while stopping
  typedef enum logic [1:0] {
    ramp_none = 2'b00,
    ramp_slow = 2'b01,
    ramp_quick = 2'b10
  } dso_ramp_t;

  // decoded control word commands
  typedef enum logic [2:0] {
    cmd_none = 3'b000,
    cmd_shutdown = 3'b001,
    cmd_switch_on = 3'b010,
    cmd_disable_voltage = 3'b011,
    cmd_quick_stop = 3'b100,
    cmd_disable_op = 3'b101,
    cmd_enable_op = 3'b110,
    cmd_fault_reset = 3'b111
  } dso_cmd_t;

endpackage

// file: dso_opt_reg.sv
`timescale 1ns/10ps
module dso_opt_reg #(
  parameter int WIDTH = 16,
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] VALID_MASK = 16'h0001
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // write side
  input wire logic i_wr,
  input wire logic [WIDTH-1:0] i_wdata,
  // stored option and write check
  output logic [WIDTH-1:0] o_value,
  output logic o_valid
);

  // legal only when small, non-negative and listed in the mask
  always_comb begin
    o_valid = 1'b0;
    if (i_wdata[WIDTH-1:4] == '0) begin
      o_valid = VALID_MASK[i_wdata[3:0]];
    end
  end

  // reserved values leave the old option in effect
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_value <= RESET_VALUE[WIDTH-1:0];
    end else if (i_wr && o_valid) begin
      o_value <= i_wdata;
    end
  end

endmodule

// file: dso_drive_status.sv
`timescale 1ns/10ps
`include "dso_cfg.svh"
module dso_drive_status #(
  parameter int DATA_W = 16,
  parameter int MODE_W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control word from the network master
  input wire logic i_ctl_valid,
  input wire logic [DATA_W-1:0] i_ctl_word,
  // object dictionary access
  input wire logic i_obj_req,
  input wire logic i_obj_wr,
  input wire logic [15:0] i_obj_index,
  input wire logic [DATA_W-1:0] i_obj_wdata,
  output logic o_obj_ack,
  output logic o_obj_err,
  output logic [DATA_W-1:0] o_obj_rdata,
  // drive conditions
  input wire logic i_init_done,
  input wire logic i_remote,
  input wire logic i_hv_present,
  input wire logic i_warning,
  input wire logic i_int_limit,
  input wire logic i_fault,
  input wire logic i_nonfatal_fault,
  input wire logic i_axis_still,
  input wire logic i_setpoint_reached,
  input wire logic i_target_write,
  // operation mode and its flags
  input wire logic [MODE_W-1:0] i_op_mode,
  input wire logic i_mode_flag_lo,
  input wire logic i_mode_flag_hi,
  // power stage control and status
  output logic o_pwr_enable,
  output logic [1:0] o_ramp_sel,
  output logic [DATA_W-1:0] o_status_word
);

  // control state
  dso_pkg::dso_state_t state;
  dso_pkg::dso_state_t next_state;
  dso_pkg::dso_state_t goal;
  dso_pkg::dso_state_t next_goal;
  dso_pkg::dso_ramp_t ramp;
  dso_pkg::dso_ramp_t next_ramp;
  logic stopping;
  logic next_stopping;
  logic qs_fault;
  logic next_qs_fault;
  logic [DATA_W-1:0] ctl_word;
  logic [DATA_W-1:0] ctl_clean;
  dso_pkg::dso_cmd_t cmd;
  logic cmd_take;
  logic stop_done;
  logic halt;
  logic tr_now;
  logic [1:0] mode_bits;

  // option registers
  logic [DATA_W-1:0] opt_qstop;
  logic [DATA_W-1:0] opt_shut;
  logic [DATA_W-1:0] opt_disop;
  logic [DATA_W-1:0] opt_fault;
  logic ok_qstop;
  logic ok_shut;
  logic ok_disop;
  logic ok_fault;
  logic wr_qstop;
  logic wr_shut;
  logic wr_disop;
  logic wr_fault;
  logic obj_write;

  // ramp chosen by an option code
  function automatic dso_pkg::dso_ramp_t opt_ramp(
    input logic [DATA_W-1:0] opt
  );
    dso_pkg::dso_ramp_t r;
    r = dso_pkg::ramp_none;
    if (opt == `DSO_OPT_SLOW || opt == `DSO_OPT_SLOW_STAY) begin
      r = dso_pkg::ramp_slow;
    end else if (opt == `DSO_OPT_QUICK ||
                 opt == `DSO_OPT_QUICK_STAY) begin
      r = dso_pkg::ramp_quick;
    end
    return r;
  endfunction

  // end state of a quick stop for an option code
  function automatic dso_pkg::dso_state_t qs_goal(
    input logic [DATA_W-1:0] opt
  );
    dso_pkg::dso_state_t g;
    g = dso_pkg::st_sw_on_disabled;
    if (opt == `DSO_OPT_SLOW_STAY || opt == `DSO_OPT_QUICK_STAY) begin
      g = dso_pkg::st_quick_stop;
    end
    return g;
  endfunction

  // object index match
  function automatic logic idx_is(
    input logic [15:0] idx,
    input logic [15:0] want
  );
    return idx == want;
  endfunction

  // control word command decode
  function automatic dso_pkg::dso_cmd_t decode(
    input logic [DATA_W-1:0] cw,
    input logic [DATA_W-1:0] prev
  );
    dso_pkg::dso_cmd_t c;
    c = dso_pkg::cmd_none;
    if (cw[`DSO_CW_FR] && !prev[`DSO_CW_FR]) begin
      c = dso_pkg::cmd_fault_reset;
    end else if (cw[`DSO_CW_FR]) begin
      c = dso_pkg::cmd_none;
    end else if (!cw[`DSO_CW_EV]) begin
      c = dso_pkg::cmd_disable_voltage;
    end else if (!cw[`DSO_CW_QS]) begin
      c = dso_pkg::cmd_quick_stop;
    end else if (!cw[`DSO_CW_SO]) begin
      c = dso_pkg::cmd_shutdown;
    end else if (cw[`DSO_CW_EO]) begin
      c = dso_pkg::cmd_enable_op;
    end else begin
      c = dso_pkg::cmd_disable_op;
    end
    return c;
  endfunction

  // reserved control bits are masked, they carry no function
  assign ctl_clean = i_ctl_word & ~`DSO_CW_RSV_MASK;

  // commands only act in remote mode
  assign cmd_take = i_ctl_valid && i_remote;
  assign cmd = decode(ctl_clean, ctl_word);
  assign halt = ctl_word[`DSO_CW_HALT];

  // a stop without ramp ends at once, else when the axis rests
  assign stop_done = (ramp == dso_pkg::ramp_none) || i_axis_still;

  // latest executed control word
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl_word <= '0;
    end else if (cmd_take) begin
      ctl_word <= ctl_clean;
    end
  end

  // device control transitions
  always_comb begin
    next_state = state;
    next_goal = goal;
    next_ramp = ramp;
    next_stopping = stopping;
    next_qs_fault = qs_fault;
    if (i_fault && state != dso_pkg::st_fault_react &&
        state != dso_pkg::st_fault) begin
      next_state = dso_pkg::st_fault_react;
      next_goal = dso_pkg::st_fault;
      next_ramp = opt_ramp(opt_fault);
      next_stopping = 1'b1;
      next_qs_fault = 1'b0;
    end else if (stopping) begin
      if (stop_done) begin
        next_state = goal;
        next_stopping = 1'b0;
        next_ramp = dso_pkg::ramp_none;
      end
    end else if (state == dso_pkg::st_not_ready) begin
      if (i_init_done) begin
        next_state = dso_pkg::st_sw_on_disabled;
      end
    end else if (i_nonfatal_fault &&
                 state == dso_pkg::st_op_enabled) begin
      next_state = dso_pkg::st_quick_stop;
      next_goal = qs_goal(opt_qstop);
      next_ramp = opt_ramp(opt_qstop);
      next_stopping = 1'b1;
      next_qs_fault = 1'b1;
    end else if (cmd_take) begin
      unique case (state)
        dso_pkg::st_not_ready, dso_pkg::st_fault_react: begin
          next_state = state;
        end
        dso_pkg::st_sw_on_disabled: begin
          if (cmd == dso_pkg::cmd_shutdown) begin
            next_state = dso_pkg::st_ready;
          end
        end
        dso_pkg::st_ready: begin
          if (cmd == dso_pkg::cmd_enable_op ||
              cmd == dso_pkg::cmd_disable_op) begin
            next_state = dso_pkg::st_switched_on;
          end else if (cmd == dso_pkg::cmd_disable_voltage ||
                       cmd == dso_pkg::cmd_quick_stop) begin
            next_state = dso_pkg::st_sw_on_disabled;
          end
        end
        dso_pkg::st_switched_on: begin
          if (cmd == dso_pkg::cmd_enable_op) begin
            next_state = dso_pkg::st_op_enabled;
          end else if (cmd == dso_pkg::cmd_shutdown) begin
            next_state = dso_pkg::st_ready;
          end else if (cmd == dso_pkg::cmd_disable_voltage ||
                       cmd == dso_pkg::cmd_quick_stop) begin
            next_state = dso_pkg::st_sw_on_disabled;
          end
        end
        dso_pkg::st_op_enabled: begin
          if (cmd == dso_pkg::cmd_shutdown) begin
            next_goal = dso_pkg::st_ready;
            next_ramp = opt_ramp(opt_shut);
            next_stopping = 1'b1;
          end else if (cmd == dso_pkg::cmd_disable_op) begin
            next_goal = dso_pkg::st_switched_on;
            next_ramp = opt_ramp(opt_disop);
            next_stopping = 1'b1;
          end else if (cmd == dso_pkg::cmd_disable_voltage) begin
            next_state = dso_pkg::st_sw_on_disabled;
          end else if (cmd == dso_pkg::cmd_quick_stop) begin
            next_state = dso_pkg::st_quick_stop;
            next_goal = qs_goal(opt_qstop);
            next_ramp = opt_ramp(opt_qstop);
            next_stopping = 1'b1;
            next_qs_fault = 1'b0;
          end
        end
        dso_pkg::st_quick_stop: begin
          // only a stay-in-quick-stop end reaches here
          if (cmd == dso_pkg::cmd_enable_op) begin
            next_state = dso_pkg::st_op_enabled;
            next_qs_fault = 1'b0;
          end else if (cmd == dso_pkg::cmd_disable_voltage) begin
            next_state = dso_pkg::st_sw_on_disabled;
            next_qs_fault = 1'b0;
          end
        end
        dso_pkg::st_fault: begin
          if (cmd == dso_pkg::cmd_fault_reset) begin
            next_state = dso_pkg::st_sw_on_disabled;
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= dso_pkg::st_not_ready;
      goal <= dso_pkg::st_not_ready;
      ramp <= dso_pkg::ramp_none;
      stopping <= 1'b0;
      qs_fault <= 1'b0;
    end else begin
      state <= next_state;
      goal <= next_goal;
      ramp <= next_ramp;
      stopping <= next_stopping;
      qs_fault <= next_qs_fault;
    end
  end

  // power stage and ramp outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pwr_enable <= 1'b0;
      o_ramp_sel <= 2'b00;
    end else begin
      o_ramp_sel <= next_ramp;
      o_pwr_enable <= 1'b0;
      if (next_stopping) begin
        o_pwr_enable <= next_ramp != dso_pkg::ramp_none;
      end else if (next_state == dso_pkg::st_op_enabled ||
                   next_state == dso_pkg::st_quick_stop) begin
        o_pwr_enable <= 1'b1;
      end
    end
  end

  // target reached source by situation
  always_comb begin
    if (halt) begin
      tr_now = i_axis_still;
    end else if (state == dso_pkg::st_quick_stop && !stopping) begin
      tr_now = i_axis_still;
    end else begin
      tr_now = i_setpoint_reached;
    end
    if (i_target_write) begin
      tr_now = 1'b0;
    end
  end

  // mode-specific flags
  always_comb begin
    mode_bits = 2'b00;
    if (i_op_mode == `DSO_MODE_PROF_POS ||
        i_op_mode == `DSO_MODE_PROF_VEL ||
        i_op_mode == `DSO_MODE_HOME_SEARCH) begin
      mode_bits = {i_mode_flag_hi, i_mode_flag_lo};
    end else if (i_op_mode == `DSO_MODE_INTERP_POS) begin
      mode_bits = {1'b0, state == dso_pkg::st_op_enabled};
    end
  end

  // status word rebuilt every cycle, nothing held
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_status_word <= '0;
    end else begin
      o_status_word <= '0;
      unique case (state)
        dso_pkg::st_not_ready: begin
          o_status_word[`DSO_SW_SOD] <= 1'b0;
        end
        dso_pkg::st_sw_on_disabled: begin
          o_status_word[`DSO_SW_SOD] <= 1'b1;
        end
        dso_pkg::st_ready: begin
          o_status_word[`DSO_SW_RTSO] <= 1'b1;
          o_status_word[`DSO_SW_QS] <= 1'b1;
        end
        dso_pkg::st_switched_on: begin
          o_status_word[`DSO_SW_RTSO] <= 1'b1;
          o_status_word[`DSO_SW_SO] <= 1'b1;
          o_status_word[`DSO_SW_QS] <= 1'b1;
        end
        dso_pkg::st_op_enabled: begin
          o_status_word[`DSO_SW_RTSO] <= 1'b1;
          o_status_word[`DSO_SW_SO] <= 1'b1;
          o_status_word[`DSO_SW_OE] <= 1'b1;
          o_status_word[`DSO_SW_QS] <= 1'b1;
        end
        dso_pkg::st_quick_stop: begin
          o_status_word[`DSO_SW_RTSO] <= 1'b1;
          o_status_word[`DSO_SW_SO] <= 1'b1;
          o_status_word[`DSO_SW_OE] <= 1'b1;
          o_status_word[`DSO_SW_FAULT] <= qs_fault;
        end
        dso_pkg::st_fault_react: begin
          o_status_word[`DSO_SW_RTSO] <= 1'b1;
          o_status_word[`DSO_SW_SO] <= 1'b1;
          o_status_word[`DSO_SW_OE] <= 1'b1;
          o_status_word[`DSO_SW_FAULT] <= 1'b1;
        end
        dso_pkg::st_fault: begin
          o_status_word[`DSO_SW_FAULT] <= 1'b1;
        end
      endcase
      o_status_word[`DSO_SW_VOLT] <= i_hv_present;
      o_status_word[`DSO_SW_WARN] <= i_warning;
      o_status_word[`DSO_SW_REMOTE] <= i_remote;
      o_status_word[`DSO_SW_TR] <= tr_now;
      o_status_word[`DSO_SW_ILIM] <= i_int_limit;
      o_status_word[`DSO_SW_MS0] <= mode_bits[0];
      o_status_word[`DSO_SW_MS1] <= mode_bits[1];
    end
  end

  // option writes, accepted in local mode as well
  assign obj_write = i_obj_req && i_obj_wr;
  assign wr_qstop = obj_write && idx_is(i_obj_index, `DSO_IDX_QSTOP);
  assign wr_shut = obj_write && idx_is(i_obj_index, `DSO_IDX_SHUT);
  assign wr_disop = obj_write && idx_is(i_obj_index, `DSO_IDX_DISOP);
  assign wr_fault = obj_write && idx_is(i_obj_index, `DSO_IDX_FAULT);

  // option code storage
  dso_opt_reg #(
    .WIDTH(DATA_W), .RESET_VALUE(`DSO_RST_QSTOP),
    .VALID_MASK(`DSO_OK_QSTOP)
  ) u_qstop (
    .i_clock(i_clock), .i_rst(i_rst), .i_wr(wr_qstop),
    .i_wdata(i_obj_wdata), .o_value(opt_qstop), .o_valid(ok_qstop)
  );
  dso_opt_reg #(
    .WIDTH(DATA_W), .RESET_VALUE(`DSO_RST_SHUT),
    .VALID_MASK(`DSO_OK_SHUT)
  ) u_shut (
    .i_clock(i_clock), .i_rst(i_rst), .i_wr(wr_shut),
    .i_wdata(i_obj_wdata), .o_value(opt_shut), .o_valid(ok_shut)
  );
  dso_opt_reg #(
    .WIDTH(DATA_W), .RESET_VALUE(`DSO_RST_DISOP),
    .VALID_MASK(`DSO_OK_DISOP)
  ) u_disop (
    .i_clock(i_clock), .i_rst(i_rst), .i_wr(wr_disop),
    .i_wdata(i_obj_wdata), .o_value(opt_disop), .o_valid(ok_disop)
  );
  dso_opt_reg #(
    .WIDTH(DATA_W), .RESET_VALUE(`DSO_RST_FAULT),
    .VALID_MASK(`DSO_OK_FAULT)
  ) u_fault (
    .i_clock(i_clock), .i_rst(i_rst), .i_wr(wr_fault),
    .i_wdata(i_obj_wdata), .o_value(opt_fault), .o_valid(ok_fault)
  );

  // object answer one cycle after the request
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_obj_ack <= 1'b0;
      o_obj_err <= 1'b0;
      o_obj_rdata <= '0;
    end else begin
      o_obj_ack <= i_obj_req;
      o_obj_err <= 1'b0;
      o_obj_rdata <= '0;
      if (i_obj_req) begin
        if (idx_is(i_obj_index, `DSO_IDX_STATUS)) begin
          o_obj_err <= i_obj_wr; // read-only
          o_obj_rdata <= o_status_word;
        end else if (idx_is(i_obj_index, `DSO_IDX_QSTOP)) begin
          o_obj_err <= i_obj_wr && !ok_qstop;
          o_obj_rdata <= opt_qstop;
        end else if (idx_is(i_obj_index, `DSO_IDX_SHUT)) begin
          o_obj_err <= i_obj_wr && !ok_shut;
          o_obj_rdata <= opt_shut;
        end else if (idx_is(i_obj_index, `DSO_IDX_DISOP)) begin
          o_obj_err <= i_obj_wr && !ok_disop;
          o_obj_rdata <= opt_disop;
        end else if (idx_is(i_obj_index, `DSO_IDX_FAULT)) begin
          o_obj_err <= i_obj_wr && !ok_fault;
          o_obj_rdata <= opt_fault;
        end else begin
          o_obj_err <= 1'b1; // unknown index
        end
      end
    end
  end

endmodule

// file: dso_chk_asserts.sv
`timescale 1ns/10ps
`include "dso_cfg.svh"
module dso_chk #(
  parameter int DATA_W = 16,
  parameter int MODE_W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // object access
  input wire logic i_obj_req,
  input wire logic i_obj_wr,
  input wire logic [15:0] i_obj_index,
  input wire logic [DATA_W-1:0] i_obj_wdata,
  input wire logic o_obj_ack,
  input wire logic o_obj_err,
  // drive conditions and status
  input wire logic i_remote,
  input wire logic i_hv_present,
  input wire logic i_warning,
  input wire logic i_int_limit,
  input wire logic i_fault,
  input wire logic i_target_write,
  input wire logic [MODE_W-1:0] i_op_mode,
  input wire logic i_mode_flag_lo,
  input wire logic i_mode_flag_hi,
  input wire logic [DATA_W-1:0] o_status_word
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  logic [3:0] lo;
  logic code_ok;
  // legal patterns of the state bits
  assign lo = o_status_word[3:0];
  assign code_ok = o_status_word[6] ? (lo == 4'h0) :
    (lo inside {4'h0, 4'h7, 4'h8, 4'hf} ||
    (o_status_word[5] && lo inside {4'h1, 4'h3}));
  // request and trigger shapes
  sequence s_live;
    !$past(i_rst);
  endsequence
  sequence s_ro_write;
    i_obj_req && i_obj_wr && i_obj_index == `DSO_IDX_STATUS;
  endsequence
  sequence s_bad_opt;
    i_obj_req && i_obj_wr && ((i_obj_wdata > 1 &&
    i_obj_index inside {`DSO_IDX_SHUT, `DSO_IDX_DISOP}) ||
    (i_obj_index == `DSO_IDX_QSTOP &&
    !(i_obj_wdata inside {0, 1, 2, 5, 6})));
  endsequence
  sequence s_flag_mode;
    i_op_mode inside {`DSO_MODE_PROF_POS, `DSO_MODE_PROF_VEL,
    `DSO_MODE_HOME_SEARCH};
  endsequence
  property p_ack;
    s_live |-> o_obj_ack == $past(i_obj_req);
  endproperty
  property p_ro;
    s_ro_write |=> o_obj_ack && o_obj_err;
  endproperty
  property p_rsv;
    s_bad_opt |=> o_obj_ack && o_obj_err;
  endproperty
  property p_code;
    code_ok;
  endproperty
  property p_bits;
    s_live |-> o_status_word[4] == $past(i_hv_present) &&
      o_status_word[7] == $past(i_warning) &&
      o_status_word[9] == $past(i_remote) &&
      o_status_word[11] == $past(i_int_limit);
  endproperty
  property p_tw;
    i_target_write |=> !o_status_word[10];
  endproperty
  property p_mode;
    s_flag_mode |=> o_status_word[13:12] ==
      {$past(i_mode_flag_hi), $past(i_mode_flag_lo)};
  endproperty
  property p_fault;
    i_fault |-> ##[1:2] o_status_word[3];
  endproperty
  a_ack: assert property (p_ack)
    else $error("answer not one cycle after request");
  a_ro: assert property (p_ro)
    else $error("status write not refused");
  a_rsv: assert property (p_rsv)
    else $error("reserved option accepted");
  a_code: assert property (p_code)
    else $error("illegal state pattern");
  a_bits: assert property (p_bits)
    else $error("condition bit does not follow input");
  a_tw: assert property (p_tw)
    else $error("reached bit kept after target change");
  a_mode: assert property (p_mode)
    else $error("mode flags wrong");
  a_fault: assert property (p_fault)
    else $error("fault not shown");
endmodule

bind dso_drive_status dso_chk #(.DATA_W(DATA_W), .MODE_W(MODE_W)) dso_chk_i (
  .i_clock, .i_rst, .i_obj_req, .i_obj_wr, .i_obj_index, .i_obj_wdata,
  .o_obj_ack, .o_obj_err, .i_remote, .i_hv_present, .i_warning,
  .i_int_limit, .i_fault, .i_target_write, .i_op_mode, .i_mode_flag_lo,
  .i_mode_flag_hi, .o_status_word);

// file: dso_master.sv
`timescale 1ns/10ps
module dso_master (
  // clock and answers
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [15:0] i_rdata,
  // commands and object requests
  output logic o_ctl_valid = 1'b0,
  output logic [15:0] o_ctl_word = 16'h0,
  output logic o_req = 1'b0,
  output logic o_wr = 1'b0,
  output logic [15:0] o_idx = 16'h0,
  output logic [15:0] o_wdata = 16'h0
);
  // one control word, then lines scrambled while idle
  task automatic ctl(input logic [15:0] w);
    @(negedge i_clock);
    o_ctl_valid = 1'b1;
    o_ctl_word = w & ~16'h0600;
    @(negedge i_clock);
    o_ctl_valid = 1'b0;
    o_ctl_word = ~o_ctl_word;
  endtask
  // one object access, answer taken mid next cycle
  task automatic obj(input logic w, input logic [15:0] x, d,
                     output logic e, output logic [15:0] r,
                     output logic a);
    @(negedge i_clock);
    o_req = 1'b1;
    o_wr = w;
    o_idx = x;
    o_wdata = d;
    @(negedge i_clock);
    o_req = 1'b0;
    o_idx = ~o_idx;
    o_wdata = ~o_wdata;
    a = i_ack;
    e = i_err;
    r = i_rdata;
  endtask
endmodule

// file: dso_drive_status_tb.sv
`timescale 1ns/10ps
`include "dso_cfg.svh"
module dso_drive_status_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic init, rem, hv, warn, lim, flt, nff, still, spr, tw, flo, fhi;
  logic cv, req, wr, ack, err, pen, e, a;
  logic [7:0] mode;
  logic [15:0] cw, idx, wd, rd, sw, r, v, pd;
  logic [1:0] ramp;
  int miscompares = 0;
  int n_checks = 0;

  // clock
  always #4 i_clock = ~i_clock;

  dso_drive_status dso_drive_status_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_ctl_valid(cv), .i_ctl_word(cw),
    .i_obj_req(req), .i_obj_wr(wr), .i_obj_index(idx), .i_obj_wdata(wd),
    .o_obj_ack(ack), .o_obj_err(err), .o_obj_rdata(rd),
    .i_init_done(init), .i_remote(rem), .i_hv_present(hv),
    .i_warning(warn), .i_int_limit(lim), .i_fault(flt),
    .i_nonfatal_fault(nff), .i_axis_still(still),
    .i_setpoint_reached(spr), .i_target_write(tw), .i_op_mode(mode),
    .i_mode_flag_lo(flo), .i_mode_flag_hi(fhi), .o_pwr_enable(pen),
    .o_ramp_sel(ramp), .o_status_word(sw));
  dso_master dso_master_inst (
    .i_clock(i_clock), .i_ack(ack), .i_err(err), .i_rdata(rd),
    .o_ctl_valid(cv), .o_ctl_word(cw), .o_req(req), .o_wr(wr),
    .o_idx(idx), .o_wdata(wd));

  // expected condition and mode bits
  function automatic logic [15:0] fl(input logic h, w, l,
      input logic [7:0] m, input logic f0, f1);
    fl = 16'h0;
    fl[4] = h;
    fl[7] = w;
    fl[11] = l;
    if (m inside {`DSO_MODE_PROF_POS, `DSO_MODE_PROF_VEL,
        `DSO_MODE_HOME_SEARCH}) begin
      fl[13:12] = {f1, f0};
    end
    if (m == `DSO_MODE_INTERP_POS) begin
      fl[12] = 1'b1;
    end
  endfunction

  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // command then state check
  task automatic go(input logic [15:0] w, exp);
    dso_master_inst.ctl(w);
    repeat (3) @(negedge i_clock);
    chk(sw & 16'h026f, exp);
  endtask
  // bounded wait for a status pattern
  task automatic wt(input logic [15:0] m, exp);
    for (int i = 0; i < 50 && (sw & m) !== exp; i++) @(negedge i_clock);
    chk(sw & m, exp);
  endtask
  task automatic ob(input logic w, input logic [15:0] x, d,
                    input logic ee, input logic [15:0] er);
    dso_master_inst.obj(w, x, d, e, r, a);
    chk({14'h0, a, e}, {14'h0, 1'b1, ee});
    if (!w) chk(r, er);
  endtask
  task automatic up;
    go(16'h0006, 16'h0221);
    go(16'h0007, 16'h0223);
    go(16'h000f, 16'h0227);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    miscompares++;
    print_verdict;
  end

  initial begin
    {init, rem, hv, warn, lim, flt, nff, still, spr, tw, flo, fhi} = '0;
    mode = 8'h00;
    pd = `DSO_RST_SHUT;
    void'($urandom(32'hab6c));
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    chk(sw & 16'h026f, 16'h0000);
    ob(1'b0, `DSO_IDX_QSTOP, 16'h0, 1'b0, 16'h0002);
    ob(1'b0, `DSO_IDX_SHUT, 16'h0, 1'b0, 16'h0000);
    ob(1'b0, `DSO_IDX_DISOP, 16'h0, 1'b0, 16'h0001);
    ob(1'b1, `DSO_IDX_STATUS, 16'h1234, 1'b1, 16'h0);
    ob(1'b0, 16'h6042, 16'h0, 1'b1, 16'h0);
    init = 1'b1;
    go(16'h0006, 16'h0040);
    ob(1'b0, `DSO_IDX_QSTOP, 16'h0, 1'b0, 16'h0002);
    rem = 1'b1;
    up;
    // random conditions in operation enabled
    repeat (20) begin
      {hv, warn, lim, flo, fhi} = 5'($urandom);
      mode = 8'($urandom % 8);
      repeat (2) @(negedge i_clock);
      chk(sw & 16'h3890, fl(hv, warn, lim, mode, flo, fhi));
      chk(sw & 16'h006f, 16'h0027);
    end
    {hv, warn, lim, flo, fhi} = '0;
    mode = 8'h00;
    // random option writes, reserved ones refused
    repeat (8) begin
      v = ($urandom % 2) ? 16'($urandom % 4) : 16'($urandom);
      ob(1'b1, `DSO_IDX_SHUT, v, v > 16'h0001, 16'h0);
      if (v <= 16'h0001) pd = v;
      ob(1'b0, `DSO_IDX_SHUT, 16'h0, 1'b0, pd);
    end
    ob(1'b1, `DSO_IDX_DISOP, `DSO_OPT_DISABLE, 1'b0, 16'h0);
    go(16'h0007, 16'h0223);
    chk({15'h0, pen}, 16'h0);
    go(16'h000f, 16'h0227);
    ob(1'b1, `DSO_IDX_SHUT, `DSO_OPT_SLOW, 1'b0, 16'h0);
    dso_master_inst.ctl(16'h0006);
    repeat (3) @(negedge i_clock);
    chk({14'h0, ramp}, 16'h0001);
    still = 1'b1;
    wt(16'h026f, 16'h0221);
    still = 1'b0;
    go(16'h0007, 16'h0223);
    go(16'h000f, 16'h0227);
    // stay-in-quick-stop options
    for (int k = 5; k < 7; k++) begin
      ob(1'b1, `DSO_IDX_QSTOP, 16'(k), 1'b0, 16'h0);
      go(16'h0002, 16'h0207);
      chk({14'h0, ramp}, 16'(k - 4));
      still = 1'b1;
      wt(16'h0400, 16'h0400);
      chk(sw & 16'h026f, 16'h0207);
      go(16'h0000, 16'h0240);
      still = 1'b0;
      up;
    end
    go(16'h010f, 16'h0227);
    chk(sw & 16'h0400, 16'h0);
    still = 1'b1;
    wt(16'h0400, 16'h0400);
    still = 1'b0;
    go(16'h000f, 16'h0227);
    spr = 1'b1;
    wt(16'h0400, 16'h0400);
    tw = 1'b1;
    @(negedge i_clock);
    tw = 1'b0;
    chk(sw & 16'h0400, 16'h0);
    spr = 1'b0;
    flt = 1'b1;
    @(negedge i_clock);
    flt = 1'b0;
    wt(16'h004f, 16'h000f);
    still = 1'b1;
    wt(16'h004f, 16'h0008);
    go(16'h0080, 16'h0240);
    still = 1'b0;
    up;
    nff = 1'b1;
    wt(16'h002f, 16'h000f);
    nff = 1'b0;
    print_verdict;
  end
endmodule
